//--- sri_pkg.sv
// Package: constants and types of the SPI instruction core
// Overview of operation
// - Short read, six-bit start, may flag range
// - Short write, six-bit start, may flag range
// - XOR write stores old byte XOR data
// - XOR write returns unaltered old byte
// - FIFO read returns and removes oldest byte
// - FIFO read on empty raises underflow
// - FIFO copy also stores bytes to memory
// - FIFO copy second byte is fill count
// - Write stores byte n at start plus n
package sri_pkg;

    // ****************************************
    // Memory space
    // ****************************************
    localparam int MEM_BYTES = 384;
    localparam int MEM_IDX_W = 9;
    localparam logic [11:0] MEM_TOP = 12'h180;
    localparam logic [11:0] SHORT_LIMIT = 12'h040;
    localparam logic [11:0] ADDR_STEP = 12'h001;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [1:0] OPC_SHORT_RD = 2'h2;
    localparam logic [1:0] OPC_SHORT_WR = 2'h3;
    localparam logic [3:0] OPC_XOR_WR = 4'h2;
    localparam logic [7:0] OPC_RX_RD = 8'h30;
    localparam logic [3:0] OPC_RX_CP = 4'h4;

    // ****************************************
    // Reset values and link constants
    // ****************************************
    localparam logic STATUS_PAD = 1'b0;
    localparam logic [7:0] TX_RST = 8'h00;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h1;
    localparam logic [2:0] BIT_NONE = 3'h0;
    localparam logic [1:0] SYNC_RST = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_OPCODE = 4'h2,
        ST_ADDR_LO = 4'h4,
        ST_DATA = 4'h8
    } sri_state_t;

    typedef enum logic [5:0] {
        OP_NONE = 6'h01,
        OP_SRD = 6'h02,
        OP_SWR = 6'h04,
        OP_XWR = 6'h08,
        OP_RXRD = 6'h10,
        OP_RXCP = 6'h20
    } sri_op_t;

endpackage

//--- sri_sync2.sv
// Two-stage synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module sri_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sri_sync_t;

    sri_sync_t st_q;
    sri_sync_t st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{s1: RST, s2: RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule
`default_nettype wire

//--- sri_spi_link.sv
// SPI shifter on the host serial clock, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
module sri_spi_link
    import sri_pkg::*;
(
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [7:0] tx_hold,
    output logic [7:0] rx_byte,
    output logic rx_tgl,
    output logic miso
);
    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sr;
        logic [7:0] rxb;
        logic tgl;
        logic first;
    } sri_rise_t;

    typedef struct packed {
        logic [7:0] sr;
        logic miso;
    } sri_fall_t;

    localparam sri_rise_t RISE_RST = '{cnt: BIT_NONE, sr: 7'h00,
        rxb: TX_RST, tgl: 1'b0, first: 1'b1};
    localparam sri_fall_t FALL_RST = '{sr: TX_RST, miso: STATUS_PAD};

    sri_rise_t r_q;
    sri_rise_t r_d;
    sri_fall_t f_q;
    sri_fall_t f_d;

    // ****************************************
    // Receive side, sampled on the rising edge
    // ****************************************
    always_comb begin
        r_d = r_q;
        r_d.cnt = r_q.cnt + BIT_STEP;
        r_d.sr = {r_q.sr[5:0], mosi};
        if (r_q.cnt == BIT_LAST) begin
            r_d.rxb = {r_q.sr, mosi};
            r_d.tgl = ~r_q.tgl;
            r_d.first = 1'b0;
        end
    end

    // The serial clock stops between frames, so only chip select can
    // bring the bit counter back in step; it clears the shifter at once.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            r_q <= RISE_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************
    // Transmit side, launched on the falling edge
    // ****************************************
    // Bit 7 of the first byte is the reset value of the pin, since no
    // edge comes before it; the status byte keeps that bit at zero.
    always_comb begin
        f_d = f_q;
        if (r_q.cnt == BIT_NONE) begin
            f_d.sr = tx_hold;
            f_d.miso = tx_hold[7];
        end else if (r_q.first && r_q.cnt == BIT_FIRST) begin
            f_d.sr = {tx_hold[6:0], 1'b0};
            f_d.miso = tx_hold[6];
        end else begin
            f_d.miso = f_q.sr[6];
            f_d.sr = {f_q.sr[6:0], 1'b0};
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            f_q <= FALL_RST;
        end else begin
            f_q <= f_d;
        end
    end

    assign rx_byte = r_q.rxb;
    assign rx_tgl = r_q.tgl;
    assign miso = f_q.miso;
endmodule
`default_nettype wire

//--- sri_spi_core.sv
// SPI instruction core: short register access, XOR write, RX FIFO reads
`timescale 1ns/1ps
`default_nettype none
module sri_spi_core
    import sri_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic [6:0] dev_status,
    input wire logic [7:0] rx_fifo_count,
    input wire logic [7:0] rx_fifo_head,
    output logic rx_fifo_pop,
    output logic exc_rx_underflow,
    output logic exc_addr_error
);
    typedef struct packed {
        sri_state_t state;
        sri_op_t op;
        logic [11:0] addr;
        logic [7:0] tx;
        logic empty_pend;
        logic pop;
        logic exc_uf;
        logic exc_ae;
        logic oe_n;
        logic tgl_ref;
    } sri_core_t;

    localparam sri_core_t CORE_RST = '{state: ST_IDLE, op: OP_NONE,
        addr: 12'h000, tx: TX_RST, empty_pend: 1'b0, pop: 1'b0,
        exc_uf: 1'b0, exc_ae: 1'b0, oe_n: 1'b1, tgl_ref: 1'b0};

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic mem_ok(input logic [11:0] a);
        return a < MEM_TOP;
    endfunction

    function automatic logic [MEM_IDX_W-1:0] mem_idx(input logic [11:0] a);
        return a[MEM_IDX_W-1:0];
    endfunction

    sri_core_t c_q;
    sri_core_t c_d;
    logic [7:0] mem_q [MEM_BYTES];
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic s_cs_n;
    logic s_tgl;
    logic evt;
    logic do_pf;
    logic mem_we;
    logic [11:0] mem_wa;
    logic [7:0] mem_wd;
    logic [11:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] cur_data;

    // ****************************************
    // Link side and crossings
    // ****************************************
    sri_spi_link u_link (
        .sclk(spi_sclk),
        .cs_n(spi_cs_n),
        .mosi(spi_mosi),
        .tx_hold(c_q.tx),
        .rx_byte(rx_byte),
        .rx_tgl(rx_tgl),
        .miso(spi_miso)
    );

    // Select and the byte toggle share one synchroniser so that the toggle
    // reset at frame end never shows up ahead of the deselect.
    sri_sync2 #(
        .W(2),
        .RST(SYNC_RST)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({spi_cs_n, rx_tgl}),
        .q({s_cs_n, s_tgl})
    );

    // A new byte is announced by a toggle; the byte itself stays put for
    // a whole byte time, so it is read directly. The answer must be back
    // in tx before the next falling edge: sclk half period >= 4 clk.
    assign evt = (s_tgl != c_q.tgl_ref) && !s_cs_n;

    // ****************************************
    // Memory read ports
    // ****************************************
    always_comb begin
        if (c_q.state == ST_OPCODE) begin
            rd_addr = {6'h00, rx_byte[5:0]};
        end else if (c_q.state == ST_ADDR_LO) begin
            rd_addr = {c_q.addr[11:8], rx_byte};
        end else begin
            rd_addr = c_q.addr + ADDR_STEP;
        end
    end

    assign rd_data = mem_ok(rd_addr) ? mem_q[mem_idx(rd_addr)] : TX_RST;
    assign cur_data = mem_ok(c_q.addr) ? mem_q[mem_idx(c_q.addr)] : TX_RST;

    // ****************************************
    // Instruction sequencer
    // ****************************************
    always_comb begin
        c_d = c_q;
        c_d.pop = 1'b0;
        c_d.exc_uf = 1'b0;
        c_d.exc_ae = 1'b0;
        c_d.tgl_ref = s_tgl;
        c_d.oe_n = s_cs_n;
        do_pf = 1'b0;
        mem_we = 1'b0;
        mem_wa = c_q.addr;
        mem_wd = rx_byte;
        case (c_q.state)
            ST_IDLE: begin
                c_d.tx = {STATUS_PAD, dev_status};
                if (!s_cs_n) begin
                    c_d.state = ST_OPCODE;
                end
            end
            ST_OPCODE: begin
                if (evt) begin
                    if (rx_byte[7:6] == OPC_SHORT_RD) begin
                        c_d.op = OP_SRD;
                        c_d.addr = {6'h00, rx_byte[5:0]};
                        c_d.tx = rd_data;
                        c_d.state = ST_DATA;
                    end else if (rx_byte[7:6] == OPC_SHORT_WR) begin
                        c_d.op = OP_SWR;
                        c_d.addr = {6'h00, rx_byte[5:0]};
                        c_d.tx = rd_data;
                        c_d.state = ST_DATA;
                    end else if (rx_byte[7:4] == OPC_XOR_WR) begin
                        c_d.op = OP_XWR;
                        c_d.addr = {rx_byte[3:0], 8'h00};
                        c_d.state = ST_ADDR_LO;
                    end else if (rx_byte == OPC_RX_RD) begin
                        c_d.op = OP_RXRD;
                        c_d.state = ST_DATA;
                        do_pf = 1'b1;
                    end else if (rx_byte[7:4] == OPC_RX_CP) begin
                        c_d.op = OP_RXCP;
                        c_d.addr = {rx_byte[3:0], 8'h00};
                        c_d.tx = rx_fifo_count;
                        c_d.state = ST_ADDR_LO;
                    end else begin
                        c_d.op = OP_NONE;
                        c_d.tx = TX_RST;
                        c_d.state = ST_DATA;
                    end
                end
            end
            ST_ADDR_LO: begin
                if (evt) begin
                    c_d.addr = {c_q.addr[11:8], rx_byte};
                    c_d.state = ST_DATA;
                    if (c_q.op == OP_XWR) begin
                        c_d.tx = rd_data;
                    end else begin
                        do_pf = 1'b1;
                    end
                end
            end
            ST_DATA: begin
                if (evt) begin
                    if (c_q.op == OP_RXRD || c_q.op == OP_RXCP) begin
                        c_d.exc_uf = c_q.empty_pend;
                        do_pf = 1'b1;
                    end else if (c_q.op != OP_NONE) begin
                        if (!mem_ok(c_q.addr)) begin
                            c_d.exc_ae = 1'b1;
                        end else if (c_q.op == OP_SWR) begin
                            mem_we = 1'b1;
                        end else if (c_q.op == OP_XWR) begin
                            mem_we = 1'b1;
                            mem_wd = cur_data ^ rx_byte;
                        end
                        c_d.addr = c_q.addr + ADDR_STEP;
                        c_d.tx = rd_data;
                    end
                end
            end
            default: begin
                c_d.state = ST_IDLE;
            end
        endcase
        // The next FIFO byte is taken when it is loaded for shifting, not
        // when it has gone out: the crossing leaves no time to fetch it
        // later. A frame cut short therefore drops the byte in flight.
        if (do_pf) begin
            if (rx_fifo_count != 8'h00) begin
                c_d.tx = rx_fifo_head;
                c_d.pop = 1'b1;
                c_d.empty_pend = 1'b0;
                if (c_d.op == OP_RXCP) begin
                    if (mem_ok(c_d.addr)) begin
                        mem_we = 1'b1;
                        mem_wa = c_d.addr;
                        mem_wd = rx_fifo_head;
                    end else begin
                        c_d.exc_ae = 1'b1;
                    end
                    c_d.addr = c_d.addr + ADDR_STEP;
                end
            end else begin
                c_d.tx = TX_RST;
                c_d.empty_pend = 1'b1;
            end
        end
        if (s_cs_n) begin
            c_d.state = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c_q <= CORE_RST;
        end else begin
            c_q <= c_d;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_q[mem_idx(mem_wa)] <= mem_wd;
        end
    end

    assign spi_miso_oe_n = c_q.oe_n;
    assign rx_fifo_pop = c_q.pop;
    assign exc_rx_underflow = c_q.exc_uf;
    assign exc_addr_error = c_q.exc_ae;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pulse(logic x);
        x ##1 !x;
    endsequence

    sequence s_pop_taken;
        c_q.pop && (c_q.tx == $past(rx_fifo_head)) ##1 !c_q.pop;
    endsequence

    chk_short_rd_start: assert property (
        (c_q.state == ST_OPCODE && evt && rx_byte[7:6] == OPC_SHORT_RD)
        |=> (c_q.op == OP_SRD && c_q.addr < SHORT_LIMIT
            && c_q.tx == mem_q[mem_idx(c_q.addr)]))
        else $error("short read did not fetch its start byte");

    chk_short_rd_range: assert property (
        (c_q.state == ST_DATA && evt && c_q.op == OP_SRD
            && !mem_ok(c_q.addr))
        |=> s_pulse(c_q.exc_ae))
        else $error("out of range read gave no address error");

    chk_short_wr_start: assert property (
        (c_q.state == ST_OPCODE && evt && rx_byte[7:6] == OPC_SHORT_WR)
        |=> (c_q.op == OP_SWR
            && c_q.addr == {6'h00, $past(rx_byte[5:0])}))
        else $error("short write start address wrong");

    chk_xor_store: assert property (
        (c_q.state == ST_DATA && evt && c_q.op == OP_XWR
            && mem_ok(c_q.addr))
        |=> mem_q[mem_idx($past(c_q.addr))]
            == ($past(cur_data) ^ $past(rx_byte)))
        else $error("xor write stored wrong value");

    chk_xor_return: assert property (
        (c_q.state == ST_DATA && evt && c_q.op == OP_XWR
            && mem_ok(c_q.addr + ADDR_STEP))
        |=> (c_q.addr == $past(c_q.addr) + ADDR_STEP
            && c_q.tx == mem_q[mem_idx(c_q.addr)]))
        else $error("xor write returned altered data");

    chk_fifo_pop: assert property (
        (c_q.state == ST_DATA && evt && c_q.op == OP_RXRD
            && rx_fifo_count != 8'h00)
        |=> s_pop_taken)
        else $error("fifo read did not take the oldest byte");

    chk_underflow: assert property (
        (c_q.state == ST_DATA && evt && c_q.empty_pend
            && (c_q.op == OP_RXRD || c_q.op == OP_RXCP))
        |=> s_pulse(c_q.exc_uf))
        else $error("empty fifo read gave no underflow");

    chk_copy_store: assert property (
        (c_q.state == ST_DATA && evt && c_q.op == OP_RXCP
            && rx_fifo_count != 8'h00 && mem_ok(c_q.addr))
        |=> (mem_q[mem_idx($past(c_q.addr))] == $past(rx_fifo_head)
            && c_q.addr == $past(c_q.addr) + ADDR_STEP && c_q.pop))
        else $error("fifo copy did not store the byte");

    chk_copy_count: assert property (
        (c_q.state == ST_OPCODE && evt && rx_byte[7:4] == OPC_RX_CP)
        |=> (c_q.tx == $past(rx_fifo_count)
            && c_q.state == ST_ADDR_LO))
        else $error("fifo copy second byte is not the count");

    chk_wr_store: assert property (
        (c_q.state == ST_DATA && evt && c_q.op == OP_SWR
            && mem_ok(c_q.addr))
        |=> (mem_q[mem_idx($past(c_q.addr))] == $past(rx_byte)
            && c_q.addr == $past(c_q.addr) + ADDR_STEP))
        else $error("short write stored wrong value");

    chk_status_held: assert property (
        (c_q.state == ST_IDLE && !s_cs_n)
        |=> (c_q.tx == {STATUS_PAD, $past(dev_status)})
            ##1 (c_q.state != ST_OPCODE || evt || $stable(c_q.tx)))
        else $error("status byte not held for the opcode byte");
endmodule
`default_nettype wire

//--- sri_host_model.sv
// Host SPI master model: mode 0, MSB first, clock only inside frames
`timescale 1ns/1ps
`default_nettype none
module sri_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    localparam int HALF = 32;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    // ****************************************
    // Frame control
    // ****************************************
    // No background move is ever started, so no FIFO read races one
    task automatic begin_frame;
        cs_n = 1'b0;
        #40;
    endtask

    // Serial clock stands low between frames; MOSI shows a stale inverse
    task automatic end_frame;
        #HALF;
        cs_n = 1'b1;
        mosi = ~mosi;
        #200;
    endtask

    // ****************************************
    // Byte transfer
    // ****************************************
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #HALF;
            sclk = 1'b1;
            rx[i] = miso;
            #HALF;
            sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Testbench for the SPI instruction core with host and RX FIFO models
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sri_pkg::*;
;
    localparam int TMO = 20000;
    logic clk, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic miso_w, flt;
    logic [6:0] dev_status;
    logic [7:0] rx_fifo_count, rx_fifo_head;
    logic rx_fifo_pop, exc_rx_underflow, exc_addr_error;
    logic [7:0] fifo_q[$];
    int err_count, samples_checked, cycles, pop_cnt, unf_cnt, aer_cnt;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Undriven MISO wanders rather than keeping a stale bit
    assign miso_w = spi_miso_oe_n ? flt : spi_miso;

    sri_host_model i_host (.sclk(spi_sclk), .cs_n(spi_cs_n),
        .mosi(spi_mosi), .miso(miso_w));

    sri_spi_core i_dut (.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .dev_status(dev_status),
        .rx_fifo_count(rx_fifo_count), .rx_fifo_head(rx_fifo_head),
        .rx_fifo_pop(rx_fifo_pop), .exc_rx_underflow(exc_rx_underflow),
        .exc_addr_error(exc_addr_error));

    // ****************************************
    // RX FIFO model, event counters, timeout
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (rx_fifo_pop === 1'b1) begin
            pop_cnt++;
            if (fifo_q.size() > 0) void'(fifo_q.pop_front());
        end
        if (exc_rx_underflow === 1'b1) unf_cnt++;
        if (exc_addr_error === 1'b1) aer_cnt++;
        if (cycles == TMO) begin
            err_count++;
            stop_test();
        end
    end

    always @(negedge clk) begin
        rx_fifo_count <= 8'(fifo_q.size());
        rx_fifo_head <= fifo_q.size() > 0 ? fifo_q[0] : ~rx_fifo_head;
        flt <= ~flt;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xb(input logic [7:0] tx, input logic [7:0] exp,
                      input string what);
        logic [7:0] got;
        i_host.xfer(tx, got);
        check(what, got, exp);
    endtask

    // Short read of three bytes from a six-bit start address
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e0,
                          input logic [7:0] e1, input logic [7:0] e2);
        i_host.begin_frame();
        xb({2'h2, a}, {1'b0, dev_status}, "read status");
        xb(8'h00, e0, "read byte 0");
        xb(8'h00, e1, "read byte 1");
        xb(8'h00, e2, "read byte 2");
        i_host.end_frame();
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Write runs across 0x3F into 0x40, then reads it back
    task automatic t_short;
        logic [7:0] rd;
        i_host.begin_frame();
        xb({2'h3, 6'h3E}, {1'b0, dev_status}, "write status");
        i_host.xfer(8'h11, rd);
        i_host.xfer(8'h22, rd);
        i_host.xfer(8'h33, rd);
        i_host.end_frame();
        rd_chk(6'h3E, 8'h11, 8'h22, 8'h33);
        // An unknown opcode answers zeros after the status byte
        i_host.begin_frame();
        xb(8'h00, {1'b0, dev_status}, "refused status");
        xb(8'h3E, 8'h00, "refused byte");
        i_host.end_frame();
        $display("test short access done");
    endtask

    task automatic t_xor;
        @(negedge clk) dev_status = 7'h25;
        i_host.begin_frame();
        xb({OPC_XOR_WR, 4'h0}, 8'h25, "xor status");
        xb(8'h3E, 8'h25, "xor status repeat");
        xb(8'hFF, 8'h11, "xor old 3E");
        xb(8'h0F, 8'h22, "xor old 3F");
        i_host.end_frame();
        rd_chk(6'h3E, 8'hEE, 8'h2D, 8'h33);
        $display("test xor write done");
    endtask

    task automatic t_fifo_rd;
        int p0;
        int u0;
        p0 = pop_cnt;
        u0 = unf_cnt;
        fifo_q = '{8'hA1, 8'hB2, 8'hC3};
        i_host.begin_frame();
        xb(OPC_RX_RD, 8'h25, "fifo status");
        xb(8'h00, 8'hA1, "fifo byte 0");
        xb(8'h00, 8'hB2, "fifo byte 1");
        xb(8'h00, 8'hC3, "fifo byte 2");
        xb(8'h00, 8'h00, "fifo empty byte");
        i_host.end_frame();
        check("pops", 8'(pop_cnt - p0), 8'h03);
        check("underflows", 8'(unf_cnt - u0), 8'h01);
        i_host.begin_frame();
        xb(OPC_RX_RD, 8'h25, "empty status");
        xb(8'h00, 8'h00, "empty byte");
        i_host.end_frame();
        check("underflows", 8'(unf_cnt - u0), 8'h02);
        $display("test fifo read done");
    endtask

    task automatic t_copy;
        int p0;
        int u0;
        p0 = pop_cnt;
        u0 = unf_cnt;
        fifo_q = '{8'h5C, 8'h6D};
        i_host.begin_frame();
        xb({OPC_RX_CP, 4'h0}, 8'h25, "copy status");
        xb(8'h3D, 8'h02, "copy fill count");
        xb(8'h00, 8'h5C, "copy byte 0");
        xb(8'h00, 8'h6D, "copy byte 1");
        i_host.end_frame();
        check("copy pops", 8'(pop_cnt - p0), 8'h02);
        check("copy underflows", 8'(unf_cnt - u0), 8'h00);
        rd_chk(6'h3D, 8'h5C, 8'h6D, 8'h2D);
        $display("test fifo copy done");
    endtask

    // Copy into the last valid byte, then an XOR run stepping past the top
    task automatic t_addr_err;
        logic [7:0] rd;
        int a0;
        logic [11:0] top;
        a0 = aer_cnt;
        top = MEM_TOP - 12'h001;
        // The copy gives the top byte a known value before the XOR reads it;
        // its second prefetch already lands past the top
        fifo_q = '{8'h96, 8'h69};
        i_host.begin_frame();
        xb({OPC_RX_CP, top[11:8]}, 8'h25, "top copy status");
        xb(top[7:0], 8'h02, "top copy count");
        xb(8'h00, 8'h96, "top copy byte");
        i_host.end_frame();
        check("copy errors past top", 8'(aer_cnt - a0), 8'h01);
        i_host.begin_frame();
        xb({OPC_XOR_WR, top[11:8]}, 8'h25, "edge status");
        i_host.xfer(top[7:0], rd);
        xb(8'h00, 8'h96, "xor old top");
        check("errors at top", 8'(aer_cnt - a0), 8'h01);
        xb(8'h00, 8'h00, "beyond top");
        i_host.end_frame();
        check("errors past top", 8'(aer_cnt - a0), 8'h02);
        $display("test address error done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        dev_status = 7'h5A;
        rx_fifo_count = 8'h00;
        rx_fifo_head = 8'h00;
        flt = 1'b0;
        repeat (8) @(negedge clk);
        check("reset oe_n", {7'h00, spi_miso_oe_n}, 8'h01);
        check("reset pulses", {5'h00, rx_fifo_pop, exc_rx_underflow,
              exc_addr_error}, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // Offset keeps the host clock out of step with the core clock
        #3.3;
        t_short();
        t_xor();
        t_fifo_rd();
        t_copy();
        t_addr_err();
        stop_test();
    end
endmodule
`default_nettype wire
